// [logic/hrbc_consts.svh]
// constants for the receive frame byte counter
`ifndef HRBC_CONSTS_SVH
`define HRBC_CONSTS_SVH
`define HRBC_CNT_W        14
`define HRBC_CNT_ZERO     14'h0000
`define HRBC_CNT_ONE      14'h0001
`define HRBC_STAT_W       5
`define HRBC_FIFO_EN_BIT  2
`endif

// [logic/hrbc_pkg.sv]
// types for the receive frame byte counter
`include "hrbc_consts.svh"
package hrbc_pkg;
    // one status fifo entry: frame status plus finished byte count
    typedef struct packed {
        logic [`HRBC_STAT_W-1:0] status;
        logic [`HRBC_CNT_W-1:0]  count;
    } hrbc_entry_type;
endpackage

// [logic/hrbc_counter.sv]
// receive frame byte counter with end-of-frame capture to the status fifo
//
// Function
// - fourteen bit counter covers frames up to 16383 bytes
// - counts only in bit-oriented synchronous mode
// - flag reception in sync mode clears the counter
// - capture of count precedes flag clear
// - each data fifo write adds one
// - end of frame pushes status with count
// - status fifo enabled by bit 2 and sync mode
// - push into full fifo sets sticky overflow
////////////////////////////////////////////////////////////////////////////////
// operation
//   all strobes come from receiver logic on the same clock and are taken on
//   the rising edge at which they stand high; every answer appears one edge
//   later, so the block adds exactly one cycle of latency to each event.
//
// timing of a frame end
//   edge n  : end of frame and flag may both stand high
//   edge n+1: push pulse is high, entry holds the pre-clear count, and the
//             live count reads zero; the push pulse lasts one cycle only
//   the entry is loaded from count_reg, not count_next, which is what keeps
//   the finished count intact when the closing flag and end of frame meet.
//
// ordering inside one cycle
//   clear beats increment: a byte written in the same cycle as a flag is
//   lost from both frames, which matches a flag that closes the frame.
//   channel reset clears whatever the mode; a flag clears only in sync mode.
//
// limitations
//   the count wraps silently past 16383 bytes; longer frames need software
//   to notice the wrap from other status.
//   the overflow flag is sticky and only drops when the fifo enable drops
//   (control bit low or mode left), matching a disable and re-enable.
//   the enable output lags the control bit by one cycle, so a partner fifo
//   that resets its pointers on it sees the drop one cycle late.
//
// reset
//   the board reset is taken asynchronously and released through two flops;
//   all state below uses the released copy, so nothing moves until the third
//   edge after the pin rises.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "hrbc_consts.svh"
module hrbc_counter
    import hrbc_pkg::*;
(
    input  wire logic                     I_SYS_CLK,
    input  wire logic                     I_RST_B,
    input  wire logic                     I_CHAN_RST,
    input  wire logic                     I_SYNC_MODE,
    input  wire logic [7:0]               I_FIFO_CTRL,
    input  wire logic                     I_FLAG_DET,
    input  wire logic                     I_EOF,
    input  wire logic                     I_DFIFO_WR,
    input  wire logic [`HRBC_STAT_W-1:0]  I_FRAME_STAT,
    input  wire logic                     I_SFIFO_FULL,
    output var  logic                     O_SFIFO_PUSH,
    output var  hrbc_entry_type           O_SFIFO_ENTRY,
    output var  logic                     O_SFIFO_EN,
    output var  logic                     O_OVERFLOW,
    output var  logic [`HRBC_CNT_W-1:0]   O_COUNT
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release: async assert, two-flop synchronised release
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rst_b = rst_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode: strobes come from same-clock receiver logic, no synchronisers
    wire logic fifo_en_bit = I_FIFO_CTRL[`HRBC_FIFO_EN_BIT];
    wire logic sfifo_en    = fifo_en_bit & I_SYNC_MODE;
    wire logic do_push     = I_EOF & sfifo_en;
    // clear wins over increment; push samples the pre-clear count
    wire logic do_clear    = I_CHAN_RST | (I_FLAG_DET & I_SYNC_MODE);
    wire logic do_inc      = I_DFIFO_WR & I_SYNC_MODE;

    logic [`HRBC_CNT_W-1:0] count_reg;
    logic [`HRBC_CNT_W-1:0] count_next;
    logic                   ovf_reg;
    logic                   ovf_next;

    // next count: clear, else wrap-around increment in 14 bits
    assign count_next = do_clear ? `HRBC_CNT_ZERO :
                        do_inc   ? count_reg + `HRBC_CNT_ONE :
                                   count_reg;

    // overflow is sticky; only disabling the status fifo clears it
    assign ovf_next = !sfifo_en ? 1'b0 :
                      (do_push & I_SFIFO_FULL) ? 1'b1 :
                      ovf_reg;

    ////////////////////////////////////////////////////////////////////////////
    // counter and overflow flag
    always_ff @(posedge I_SYS_CLK or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= `HRBC_CNT_ZERO;
            ovf_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            ovf_reg   <= ovf_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; entry captures the count before the flag clear lands
    always_ff @(posedge I_SYS_CLK or negedge rst_b) begin
        if (!rst_b) begin
            O_SFIFO_PUSH  <= 1'b0;
            O_SFIFO_ENTRY <= '0;
            O_SFIFO_EN    <= 1'b0;
        end else begin
            O_SFIFO_PUSH <= do_push & ~I_SFIFO_FULL;
            O_SFIFO_EN   <= sfifo_en;
            if (do_push) begin
                O_SFIFO_ENTRY <= '{status: I_FRAME_STAT, count: count_reg};
            end
        end
    end

    assign O_OVERFLOW = ovf_reg;
    assign O_COUNT    = count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_CLEAR: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (I_FLAG_DET && I_SYNC_MODE) |=> (count_reg == `HRBC_CNT_ZERO))
        else $error("flag did not clear counter");
    AST_INC: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_inc && !do_clear) |=> (count_reg == $past(count_reg) + `HRBC_CNT_ONE))
        else $error("data write did not advance counter");
    AST_MODE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (!I_SYNC_MODE && !I_CHAN_RST) |=> $stable(count_reg))
        else $error("counter moved outside sync mode");
    AST_CAPTURE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_push && I_FLAG_DET) |=> (O_SFIFO_ENTRY.count == $past(count_reg)))
        else $error("count lost to flag clear");
    AST_PUSH: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_push && !I_SFIFO_FULL) |=> O_SFIFO_PUSH)
        else $error("end of frame not pushed");
    AST_ENABLE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        O_SFIFO_PUSH |-> $past(fifo_en_bit && I_SYNC_MODE))
        else $error("push while fifo disabled");
    AST_OVF: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_push && I_SFIFO_FULL) |=> (O_OVERFLOW && !O_SFIFO_PUSH))
        else $error("overflow not flagged");
    AST_OVF_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (O_OVERFLOW && sfifo_en) |=> O_OVERFLOW)
        else $error("overflow dropped while enabled");
    AST_CHRST: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        I_CHAN_RST |=> (count_reg == `HRBC_CNT_ZERO))
        else $error("channel reset did not clear counter");
    AST_WRAP: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_inc && !do_clear && (&count_reg)) |=> (count_reg == `HRBC_CNT_ZERO))
        else $error("14-bit wrap wrong");

    // frame status travels with the count in the same entry
    AST_STAT_CAPTURE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        do_push |=> (O_SFIFO_ENTRY.status == $past(I_FRAME_STAT)))
        else $error("frame status not captured");
    // entry stands until the next end of frame, so a slow fifo can still take it
    AST_ENTRY_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        !do_push |=> $stable(O_SFIFO_ENTRY))
        else $error("entry changed without end of frame");
    // no push pulse without an accepted end of frame
    AST_NO_PUSH: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        !do_push |=> !O_SFIFO_PUSH)
        else $error("push without end of frame");
    // enable output follows bit and mode one cycle late
    AST_EN_HIGH: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        sfifo_en |=> O_SFIFO_EN)
        else $error("fifo enable not raised");
    AST_EN_LOW: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        !sfifo_en |=> !O_SFIFO_EN)
        else $error("fifo enable not dropped");
    // dropping the enable is the only way to clear the overflow flag
    AST_OVF_CLEAR: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        !sfifo_en |=> !O_OVERFLOW)
        else $error("overflow not cleared by disable");
    // overflow rises only on a push into a full fifo
    AST_OVF_ONLY_FULL: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (!O_OVERFLOW && !(do_push && I_SFIFO_FULL)) |=> !O_OVERFLOW)
        else $error("overflow set without full push");
    // counter stands still without a byte write or a clear
    AST_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (!do_inc && !do_clear) |=> $stable(count_reg))
        else $error("counter moved without a byte");
    // a flag outside sync mode must not clear the count
    AST_FLAG_IGNORED: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (I_FLAG_DET && !I_SYNC_MODE && !I_CHAN_RST) |=> $stable(count_reg))
        else $error("flag cleared counter outside sync mode");
    // clear wins when a byte and a flag share a cycle
    AST_CLEAR_WINS: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        (do_clear && do_inc) |=> (count_reg == `HRBC_CNT_ZERO))
        else $error("increment beat the clear");
    // live count output mirrors the counter register
    AST_COUNT_OUT: assert property (@(posedge I_SYS_CLK) disable iff (!rst_b)
        do_inc |=> (O_COUNT == count_reg))
        else $error("count output differs from counter");

endmodule // hrbc_counter
`default_nettype wire

// [verif/hrbc_sfifo_model.sv]
// status fifo stand-in that reports full after DEPTH pushes
`timescale 1ns/1ps
`default_nettype none
module hrbc_sfifo_model #(parameter int DEPTH = 3) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_en,
    input  wire logic i_push,
    output var  logic o_full
);
    int fill_reg;
    // pointers drop while disabled, so a full fifo empties on re-enable
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b) fill_reg <= 0;
        else if (!i_en) fill_reg <= 0;
        else if (i_push && fill_reg < DEPTH) fill_reg <= fill_reg + 1;
    assign o_full = (fill_reg == DEPTH);
endmodule // hrbc_sfifo_model
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the receive frame byte counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hrbc_pkg::*;
    logic clk = 0, rst_b = 0, crst = 0, sync = 0, wr = 0, eof = 0, flg = 0;
    logic [7:0] ctrl = 8'h00;
    logic [4:0] stat = 5'h00;
    logic push, en, ovf, full;
    logic [13:0] cnt, exp_cnt = 14'h0000;
    hrbc_entry_type ent, q[$];
    int err_total = 0, tests_run = 0;
    hrbc_counter i_hrbc_counter (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CHAN_RST(crst),
        .I_SYNC_MODE(sync), .I_FIFO_CTRL(ctrl), .I_FLAG_DET(flg), .I_EOF(eof),
        .I_DFIFO_WR(wr), .I_FRAME_STAT(stat), .I_SFIFO_FULL(full), .O_SFIFO_PUSH(push),
        .O_SFIFO_ENTRY(ent), .O_SFIFO_EN(en), .O_OVERFLOW(ovf), .O_COUNT(cnt));
    hrbc_sfifo_model i_hrbc_sfifo_model (.i_clk(clk), .i_rst_b(rst_b), .i_en(en),
        .i_push(push), .o_full(full));
    initial forever #50 clk = ~clk;
    task automatic chk(string nm, logic [18:0] e, logic [18:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one cycle of strobes; the expected count follows clear-beats-increment
    task automatic cyc(logic w, logic e, logic f);
        wr = w; eof = e; flg = f; stat = 5'($urandom);
        if (e && ctrl[2] && sync && !full) q.push_back({stat, exp_cnt});
        if (crst || (f && sync)) exp_cnt = 14'h0000;
        else if (w && sync) exp_cnt++;
        @(posedge clk); #10;
        chk("count", 19'(exp_cnt), 19'(cnt));
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // each push takes the oldest note; a push with none pending is wrong
    always @(negedge clk) if (push === 1'b1) begin
        if (q.size() == 0) chk("push", 19'h0, 19'h1);
        else chk("entry", q.pop_front(), ent);
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        close_out;
    end
    // main sequence: frames, overflow, mode gating, channel reset, wrap
    initial begin
        void'($urandom(62));
        repeat (20) @(posedge clk);
        #10 rst_b = 1;
        repeat (3) cyc(0, 0, 0);
        sync = 1; ctrl = 8'h04;
        repeat (2) cyc(0, 0, 0);
        chk("enable", 19'h1, 19'(en));
        for (int f = 0; f < 4; f++) begin
            repeat ($urandom_range(1, 9)) cyc(1, 0, 0);
            cyc(0, 1, 1);
        end
        chk("overflow", 19'h1, 19'(ovf));
        ctrl = 8'h00;
        repeat (2) cyc(0, 0, 0);
        chk("overflow", 19'h0, 19'(ovf));
        chk("enable", 19'h0, 19'(en));
        cyc(1, 1, 0);
        sync = 0; ctrl = 8'h04;
        repeat (5) cyc(1, 1, 1);
        chk("enable", 19'h0, 19'(en));
        crst = 1;
        cyc(0, 0, 0);
        crst = 0; sync = 1;
        repeat (16384) cyc(1, 0, 0);
        chk("pending", 19'h0, 19'(q.size()));
        close_out;
    end
endmodule // tb_top
`default_nettype wire
